// [include/dcd_pkg.sv]
/*
  Constants, carrier types and command decode for the direct command
  decoder. Assumes a single 250 MHz system clock and that command
  strobes arrive from logic already on that clock.
*/
// What this block does
// - slow-control 0x5300 resets everything plus cards
// - reset codes 0x5300/0x5302 only from slow control
// - data link value 0x2 means global reset
// - 0x5301 pulses card reset, registers kept
// - data link value 0x8 means card reset
// - 0x5302 returns state machines to initial states
// - state-machine reset keeps config and status
// - data link value 0x4 means state-machine reset
// - 0x5303 cards off 4.0us, then active list
// - 0x5304 starts the instruction sequencer
// - 0x5305 aborts sequencer back to idle
// - 0x5306 sends level1 then level2 accept
// - level1 to level2 delay from 13-bit field
// - level1 on sampling clock, two cycles long
// - level2 aligned to the readout clock
// - 0x5307 clears error and status registers
// - data link value 0x10000 clears status registers
// - 0x5309 clears all counters
// - 0x530a arms sampling clock synchronisation
// - first level0 after arming resets sampling clock
// - direct commands never write result memory
package dcd_pkg;

  // slow-control command codes
  localparam logic [15:0] SC_GLOBAL_RST = 16'h5300;
  localparam logic [15:0] SC_CARD_RST   = 16'h5301;
  localparam logic [15:0] SC_SM_RST     = 16'h5302;
  localparam logic [15:0] SC_RECYCLE    = 16'h5303;
  localparam logic [15:0] SC_SEQ_START  = 16'h5304;
  localparam logic [15:0] SC_SEQ_ABORT  = 16'h5305;
  localparam logic [15:0] SC_SOFT_TRIG  = 16'h5306;
  localparam logic [15:0] SC_CLR_STATUS = 16'h5307;
  localparam logic [15:0] SC_CLR_COUNT  = 16'h5309;
  localparam logic [15:0] SC_ARM_SYNC   = 16'h530a;

  // data link send-command values
  localparam int          DL_W          = 17;
  localparam logic [16:0] DL_GLOBAL_RST = 17'h00002;
  localparam logic [16:0] DL_SM_RST     = 17'h00004;
  localparam logic [16:0] DL_CARD_RST   = 17'h00008;
  localparam logic [16:0] DL_CLR_STATUS = 17'h10000;

  // timing
  localparam int MCLK_PERIOD_NS = 4;
  localparam int CARD_OFF_NS    = 4000; // 4.0 us
  localparam int CARD_OFF_CYC   =
    (CARD_OFF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int OFF_W          = $clog2(CARD_OFF_CYC + 1);
  localparam int DLY_W          = 13;
  localparam logic [1:0] L1_HOLD_TICKS = 2'h2;

  // one strobe per decoded action
  typedef struct packed {
    logic global_rst;
    logic card_rst;
    logic sm_rst;
    logic recycle;
    logic seq_start;
    logic seq_abort;
    logic soft_trig;
    logic clr_status;
    logic clr_count;
    logic arm_sync;
  } dcd_act_s;

  // software trigger sequence
  typedef enum logic [2:0] {
    TRIG_IDLE,
    TRIG_WAIT_SAMP,
    TRIG_L1,
    TRIG_DELAY,
    TRIG_WAIT_RDO,
    TRIG_L2
  } dcd_trig_e;

  // slow-control codes; anything else gives no action
  function automatic dcd_act_s dcd_decode_sc(input logic [15:0] code);
    dcd_act_s a;
    a = '0;
    if (code == SC_GLOBAL_RST) a.global_rst = 1'b1;
    else if (code == SC_CARD_RST) a.card_rst = 1'b1;
    else if (code == SC_SM_RST) a.sm_rst = 1'b1;
    else if (code == SC_RECYCLE) a.recycle = 1'b1;
    else if (code == SC_SEQ_START) a.seq_start = 1'b1;
    else if (code == SC_SEQ_ABORT) a.seq_abort = 1'b1;
    else if (code == SC_SOFT_TRIG) a.soft_trig = 1'b1;
    else if (code == SC_CLR_STATUS) a.clr_status = 1'b1;
    else if (code == SC_CLR_COUNT) a.clr_count = 1'b1;
    else if (code == SC_ARM_SYNC) a.arm_sync = 1'b1;
    return a;
  endfunction

  // data link values; slow-control codes mean nothing here
  function automatic dcd_act_s dcd_decode_dl(input logic [16:0] val);
    dcd_act_s a;
    a = '0;
    if (val == DL_GLOBAL_RST) a.global_rst = 1'b1;
    else if (val == DL_SM_RST) a.sm_rst = 1'b1;
    else if (val == DL_CARD_RST) a.card_rst = 1'b1;
    else if (val == DL_CLR_STATUS) a.clr_status = 1'b1;
    return a;
  endfunction

endpackage

// [rtl/dcd_edge_sync.sv]
/*
  Two-flop synchroniser with rising-edge detect for one pin.
  Assumes the pin is slow against mclk (under half its rate).
*/
`timescale 1ns/1ps
module dcd_edge_sync (
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // pin side
  input  wire logic pin,
  // synchronised side
  output logic      rise
);

  typedef struct packed {
    logic meta;
    logic stable;
    logic last;
    logic rise;
  } dcd_sync_s;

  dcd_sync_s st;
  dcd_sync_s next_st;

  // meta is read only by the stable flop
  always_comb begin
    next_st        = st;
    next_st.meta   = pin;
    next_st.stable = st.meta;
    next_st.last   = st.stable;
    next_st.rise   = st.stable & ~st.last;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise = st.rise;

endmodule

// [rtl/dcd_decoder.sv]
/*
  Direct command decoder: takes command strobes from the slow-control
  port and the detector data link and turns them into action strobes,
  the card power re-cycle, the software trigger and the sampling clock
  synchronisation. Assumes both command ports are on mclk; sampling
  clock, readout clock and level0 trigger are pins from elsewhere.
*/
`timescale 1ns/1ps
module dcd_decoder
  import dcd_pkg::*;
#(
  parameter int N_CARDS = 32
) (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       nrst,
  // slow-control command port
  input  wire logic                       sc_valid,
  input  wire logic [15:0]                sc_code,
  // detector data link send-command port
  input  wire logic                       dl_valid,
  input  wire logic [dcd_pkg::DL_W-1:0]   dl_value,
  // configuration held elsewhere
  input  wire logic [N_CARDS-1:0]         active_cards,
  input  wire logic [dcd_pkg::DLY_W-1:0]  l1_l2_delay,
  // pins from outside the mclk domain
  input  wire logic                       samp_clk_pin,
  input  wire logic                       rdo_clk_pin,
  input  wire logic                       level0_trigger,
  // reset strobes
  output logic                            global_reset,
  output logic                            card_reset,
  output logic                            sm_reset,
  // sequencer and register strobes
  output logic                            seq_start,
  output logic                            seq_abort,
  output logic                            clear_status,
  output logic                            clear_counters,
  output logic                            result_we,
  // front-end card power
  output logic [N_CARDS-1:0]              card_power,
  output logic                            recycle_busy,
  // triggers to the cards
  output logic                            level1_accept,
  output logic                            level2_accept,
  // sampling clock synchronisation
  output logic                            sync_armed,
  output logic                            samp_clk_reset
);

  typedef struct packed {
    dcd_act_s           strobe;
    logic               result_we;
    logic [N_CARDS-1:0] power;
    logic               recycling;
    logic [OFF_W-1:0]   off_cnt;
    dcd_trig_e          trig;
    logic [1:0]         hold;
    logic [DLY_W-1:0]   dly;
    logic               l1;
    logic               l2;
    logic               armed;
    logic               samp_rst;
  } dcd_reg_s;

  localparam logic [OFF_W-1:0] OFF_LAST =
    OFF_W'(CARD_OFF_CYC - 1);

  dcd_reg_s st;
  dcd_reg_s next_st;
  dcd_act_s sc_act;
  dcd_act_s dl_act;
  dcd_act_s act;
  logic     samp_tick;
  logic     rdo_tick;
  logic     l0_tick;
  logic     sm_init;

  // pins cross into mclk before anything looks at them
  dcd_edge_sync u_samp (
    .mclk (mclk),
    .nrst (nrst),
    .pin  (samp_clk_pin),
    .rise (samp_tick)
  );

  dcd_edge_sync u_rdo (
    .mclk (mclk),
    .nrst (nrst),
    .pin  (rdo_clk_pin),
    .rise (rdo_tick)
  );

  dcd_edge_sync u_l0 (
    .mclk (mclk),
    .nrst (nrst),
    .pin  (level0_trigger),
    .rise (l0_tick)
  );

  // both ports decode in parallel so neither loses a command
  always_comb begin
    sc_act = '0;
    dl_act = '0;
    if (sc_valid) begin
      sc_act = dcd_decode_sc(sc_code);
    end
    if (dl_valid) begin
      dl_act = dcd_decode_dl(dl_value);
    end
    act = sc_act | dl_act;
  end

  // global reset also takes the state machines home
  assign sm_init = act.global_rst | act.sm_rst;

  always_comb begin
    next_st = st;

    // action strobes last exactly one mclk cycle
    next_st.strobe = act;
    next_st.strobe.card_rst = act.card_rst | act.global_rst;
    next_st.strobe.sm_rst = sm_init;

    // no direct command ever writes a result word
    next_st.result_we = 1'b0;

    // card power: follow active list, or hold off while re-cycling
    if (st.recycling) begin
      next_st.power = '0;
      if (st.off_cnt == OFF_LAST) begin
        next_st.recycling = 1'b0;
        next_st.off_cnt   = '0;
        next_st.power     = active_cards;
      end else begin
        next_st.off_cnt = st.off_cnt + 1'b1;
      end
    end else begin
      next_st.power = active_cards;
      if (act.recycle) begin
        next_st.recycling = 1'b1;
        next_st.off_cnt   = '0;
        next_st.power     = '0;
      end
    end
    // a re-cycle request while one runs is dropped here
    if (act.global_rst) begin
      next_st.recycling = 1'b0;
      next_st.off_cnt   = '0;
      next_st.power     = active_cards;
    end

    // software trigger sequence
    case (st.trig)
      TRIG_IDLE: begin
        next_st.l1 = 1'b0;
        next_st.l2 = 1'b0;
        if (act.soft_trig) begin
          next_st.trig = TRIG_WAIT_SAMP;
        end
      end
      TRIG_WAIT_SAMP: begin
        if (samp_tick) begin
          next_st.trig = TRIG_L1;
          next_st.l1   = 1'b1;
          next_st.hold = '0;
        end
      end
      TRIG_L1: begin
        // high across two sampling periods
        if (samp_tick) begin
          if (st.hold == L1_HOLD_TICKS - 2'h1) begin
            next_st.l1   = 1'b0;
            next_st.dly  = l1_l2_delay;
            next_st.trig = TRIG_DELAY;
          end else begin
            next_st.hold = st.hold + 2'h1;
          end
        end
      end
      TRIG_DELAY: begin
        // latency counted in readout clock periods
        if (st.dly == '0) begin
          next_st.trig = TRIG_WAIT_RDO;
        end else if (rdo_tick) begin
          next_st.dly = st.dly - 1'b1;
        end
      end
      TRIG_WAIT_RDO: begin
        if (rdo_tick) begin
          next_st.l2   = 1'b1;
          next_st.trig = TRIG_L2;
        end
      end
      TRIG_L2: begin
        // one readout period wide
        if (rdo_tick) begin
          next_st.l2   = 1'b0;
          next_st.trig = TRIG_IDLE;
        end
      end
      default: begin
        next_st.trig = TRIG_IDLE;
      end
    endcase
    // a trigger command while busy is ignored by the case above
    if (sm_init) begin
      next_st.trig = TRIG_IDLE;
      next_st.l1   = 1'b0;
      next_st.l2   = 1'b0;
      next_st.hold = '0;
      next_st.dly  = '0;
    end

    // sampling clock synchronisation: one shot per arming
    next_st.samp_rst = 1'b0;
    if (st.armed && l0_tick) begin
      next_st.samp_rst = 1'b1;
      next_st.armed    = 1'b0;
    end
    if (act.global_rst) begin
      next_st.armed = 1'b0;
    end
    // arming wins over a level0 in the same cycle
    if (act.arm_sync) begin
      next_st.armed = 1'b1;
    end
  end

  // whole state in one register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flops
  assign global_reset   = st.strobe.global_rst;
  assign card_reset     = st.strobe.card_rst;
  assign sm_reset       = st.strobe.sm_rst;
  assign seq_start      = st.strobe.seq_start;
  assign seq_abort      = st.strobe.seq_abort;
  assign clear_status   = st.strobe.clr_status;
  assign clear_counters = st.strobe.clr_count;
  assign result_we      = st.result_we;
  assign card_power     = st.power;
  assign recycle_busy   = st.recycling;
  assign level1_accept  = st.l1;
  assign level2_accept  = st.l2;
  assign sync_armed     = st.armed;
  assign samp_clk_reset = st.samp_rst;

endmodule

// [tb/dcd_far_end.sv]
/*
  far side model: command sender for both ports, clock and level0 pins.
  assumes the bench calls send and pulse_l0 from its own process.
*/
`timescale 1ns/1ps
module dcd_far_end (
  // system clock
  input  wire logic        mclk,
  // command ports
  output logic             sc_valid,
  output logic [15:0]      sc_code,
  output logic             dl_valid,
  output logic [16:0]      dl_value,
  // pins, 40 ns and 24 ns periods
  output logic             samp_clk_pin,
  output logic             rdo_clk_pin,
  output logic             level0_trigger
);
  // idle values at time zero
  initial begin
    sc_valid = '0;
    dl_valid = '0;
    sc_code = '0;
    dl_value = '0;
    level0_trigger = '0;
    samp_clk_pin = '0;
    rdo_clk_pin = '0;
  end
  // free-running pins, edges kept off the mclk rising edge
  always #20 samp_clk_pin = ~samp_clk_pin;
  always #12 rdo_clk_pin = ~rdo_clk_pin;

  // one strobe, held for exactly one rising edge
  task automatic send(input logic dl, input logic [16:0] v);
    @(negedge mclk);
    if (dl) begin
      dl_valid = '1;
      dl_value = v;
    end else begin
      sc_valid = '1;
      sc_code = v[15:0];
    end
    @(negedge mclk);
    sc_valid = '0;
    dl_valid = '0;
    // released lines must not keep the old code
    sc_code = ~sc_code;
    dl_value = ~dl_value;
  endtask

  // slow pulse so the synchroniser sees it
  task automatic pulse_l0;
    level0_trigger = '1;
    #16 level0_trigger = '0;
    #16;
  endtask
endmodule

// [tb/dcd_decoder_assertions.sv]
/*
  port checker for the direct command decoder.
  assumes it is bound onto every dcd_decoder instance.
*/
`timescale 1ns/1ps
module dcd_decoder_assertions #(
  parameter int N_CARDS = 32
) (
  // clock and reset
  input wire logic                     mclk,
  input wire logic                     nrst,
  // command ports
  input wire logic                     sc_valid,
  input wire logic [15:0]              sc_code,
  input wire logic                     dl_valid,
  input wire logic [dcd_pkg::DL_W-1:0] dl_value,
  // outputs watched
  input wire logic                     global_reset,
  input wire logic                     card_reset,
  input wire logic                     sm_reset,
  input wire logic                     seq_start,
  input wire logic                     clear_status,
  input wire logic                     clear_counters,
  input wire logic                     result_we,
  input wire logic [N_CARDS-1:0]       card_power,
  input wire logic                     recycle_busy,
  input wire logic                     sync_armed,
  input wire logic                     samp_clk_reset
);
  import dcd_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  // length of the current off interval
  logic [9:0] busy_cnt;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) busy_cnt <= '0;
    else busy_cnt <= recycle_busy ? busy_cnt + 10'h1 : '0;
  end

  // a slow-control or link command taken at this edge
  sequence sc_cmd(logic [15:0] c);
    sc_valid && sc_code == c;
  endsequence
  sequence dl_cmd(logic [16:0] v);
    dl_valid && dl_value == v && !sc_valid;
  endsequence

  global_sc_a: assert property (sc_cmd(16'h5300) |=> global_reset && card_reset && sm_reset)
    else $error("global reset not pulsed");
  dl_refuse_a: assert property (dl_cmd(17'h05300) |=> !global_reset && !sm_reset)
    else $error("link took a slow-control code");
  global_dl_a: assert property (dl_cmd(17'h00002) |=> global_reset)
    else $error("link global reset lost");
  card_rst_a: assert property (sc_cmd(16'h5301) |=> card_reset && !global_reset)
    else $error("card reset wrong");
  sm_rst_a: assert property (sc_cmd(16'h5302) |=> sm_reset && !global_reset && !clear_status)
    else $error("state reset wrong");
  recycle_a: assert property (sc_valid && sc_code == 16'h5303 && !recycle_busy
    |=> recycle_busy && card_power == '0)
    else $error("cards not switched off");
  off_time_a: assert property ($fell(recycle_busy) && !global_reset
    |-> busy_cnt == 10'(CARD_OFF_CYC))
    else $error("off interval length wrong");
  seq_go_a: assert property (sc_cmd(16'h5304) |=> seq_start)
    else $error("sequencer not started");
  arm_sync_a: assert property (sc_cmd(16'h530a) |=> sync_armed)
    else $error("sync not armed");
  sync_once_a: assert property (samp_clk_reset |-> $past(sync_armed))
    else $error("sampling reset without arming");
  no_result_a: assert property (!result_we)
    else $error("result memory written");
  no_strobe_a: assert property (!sc_valid && !dl_valid
    |=> !(global_reset || sm_reset || seq_start || clear_counters))
    else $error("strobe without command");
endmodule

bind dcd_decoder dcd_decoder_assertions #(.N_CARDS(N_CARDS)) chk (.*);

// [tb/direct_command_decoder_bench.sv]
/*
  self-checking bench for the direct command decoder.
  assumes dcd_far_end sends commands and makes the pins.
*/
`timescale 1ns/1ps
module direct_command_decoder_bench;
  import dcd_pkg::*;
  logic        mclk, nrst, sc_valid, dl_valid, samp_clk_pin, rdo_clk_pin;
  logic        level0_trigger, global_reset, card_reset, sm_reset, seq_start;
  logic        seq_abort, clear_status, clear_counters, result_we, recycle_busy;
  logic        level1_accept, level2_accept, sync_armed, samp_clk_reset;
  logic [15:0] sc_code;
  logic [16:0] dl_value;
  logic [31:0] active_cards, card_power;
  logic [12:0] l1_l2_delay;
  logic [6:0]  stb;
  int          errors, compares, pulses;

  assign stb = {global_reset, card_reset, sm_reset, seq_start, seq_abort, clear_status,
                clear_counters};
  dcd_decoder DUT (.*);
  dcd_far_end far (.*);

  // clock and sampling-reset pulse count
  initial begin
    mclk = '0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) if (samp_clk_reset === 1'h1) pulses++;

  task conclude;
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // leaves us one cycle after the command edge
  task cmd(input logic dl, input logic [16:0] v);
    far.send(dl, v);
    @(negedge mclk);
  endtask

  // strobe present for one cycle only; send returns inside that cycle
  task strobe(input logic dl, input logic [16:0] v, input logic [6:0] e);
    far.send(dl, v);
    chk(stb, e);
    @(negedge mclk);
    chk(stb, '0);
  endtask

  // cycles while a trigger line holds v; bounded
  task cnt(input logic s, input logic v, output int n);
    n = 0;
    while ((s ? level2_accept : level1_accept) === v && n < 300) begin
      @(negedge mclk);
      n++;
    end
    if (n == 300) begin
      errors++;
      conclude;
    end
  endtask

  task t_sc_codes;
    strobe(0, 17'h05300, 7'h70);
    strobe(0, 17'h05301, 7'h20);
    strobe(0, 17'h05302, 7'h10);
    strobe(0, 17'h05304, 7'h08);
    strobe(0, 17'h05305, 7'h04);
    strobe(0, 17'h05307, 7'h02);
    strobe(0, 17'h05309, 7'h01);
    strobe(0, 17'h05308, 7'h00);
  endtask

  task t_dl_codes;
    strobe(1, 17'h00002, 7'h70);
    strobe(1, 17'h00008, 7'h20);
    strobe(1, 17'h00004, 7'h10);
    strobe(1, 17'h10000, 7'h02);
    strobe(1, 17'h05300, 7'h00);
    strobe(1, 17'h05302, 7'h00);
  endtask

  // samp period 10 cycles, readout period 6, delay 3
  task t_trigger;
    int n;
    cmd(0, 17'h05306);
    cnt(0, 0, n);
    cnt(0, 1, n);
    chk(n, 20);
    cnt(1, 0, n);
    chk(n > 18 && n <= 27, 1);
    cnt(1, 1, n);
    chk(n, 6);
  endtask

  task t_sm_reset;
    int n;
    cmd(0, 17'h0530a);
    cmd(0, 17'h05306);
    cnt(0, 0, n);
    cmd(0, 17'h05302);
    @(negedge mclk);
    chk(level1_accept, 0);
    chk(sync_armed, 1);
    cmd(0, 17'h05300);
    chk(sync_armed, 0);
  endtask

  task t_sync;
    int p;
    cmd(0, 17'h0530a);
    chk(sync_armed, 1);
    p = pulses;
    far.pulse_l0();
    far.pulse_l0();
    repeat (4) @(negedge mclk);
    chk(pulses - p, 1);
    chk(sync_armed, 0);
  endtask

  // second re-cycle mid-interval must not stretch it
  task t_recycle;
    int n;
    cmd(0, 17'h05303);
    chk(card_power, 0);
    chk(recycle_busy, 1);
    n = 1;
    while (recycle_busy === 1'h1 && n < 1100) begin
      if (n == 500) begin
        far.send(0, 17'h05303);
        n += 2;
      end else begin
        @(negedge mclk);
        n++;
      end
    end
    chk(n, CARD_OFF_CYC);
    chk(card_power, active_cards);
  endtask

  initial begin
    nrst = '0;
    errors = 0;
    compares = 0;
    pulses = 0;
    active_cards = 32'h9a5c3e71;
    l1_l2_delay = 13'h0003;
    repeat (16) @(negedge mclk);
    nrst = '1;
    t_sc_codes();
    t_dl_codes();
    t_trigger();
    t_sm_reset();
    t_sync();
    t_recycle();
    conclude();
  end
endmodule
